// ==== tb/test_uart_interrupt_status.sv ====
// Self-checking bench for the serial port event status, mask and clear block.
// Assumes uis_top as an APB slave on one 100 MHz clock, events driven here.
`timescale 1ns/10ps
module test_uart_interrupt_status;
	// ==========================================
	// Stimulus and observed signals
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [9:0] ev = 10'h000;
	logic [31:0] prdata;
	logic [31:0] dma_control;
	logic [31:0] event_mask;
	logic pready;
	logic pslverr;
	logic uart_irq;
	logic [31:0] rd;
	logic [31:0] b;
	logic err;
	int errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	int pos[10] = '{1, 4, 5, 6, 7, 8, 9, 10, 11, 12};

	uis_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cts_event(ev[0]), .receive_event(ev[1]), .transmit_event(ev[2]), .rx_timeout_event(ev[3]),
		.framing_event(ev[4]), .parity_event(ev[5]), .break_event(ev[6]), .overrun_event(ev[7]),
		.flow_stop_event(ev[8]), .tx_empty_event(ev[9]), .dma_control(dma_control),
		.event_mask(event_mask), .uart_irq(uart_irq));

	initial begin
		forever #5 pclk = ~pclk;
	end

	// ==========================================
	// Hang guard, well above the few hundred cycles the tests need
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			errors++;
			give_verdict();
		end
	end

	// ==========================================
	// Tasks
	task automatic give_verdict();
		if (errors == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Idle edge first, so a release and the next setup never share a time step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the hang guard ends a wait for the answer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(what, exp, rd);
	endtask

	task automatic fire(input logic [9:0] v);
		@(posedge pclk);
		ev <= v;
		@(posedge pclk);
		ev <= 10'h000;
	endtask

	// ==========================================
	// Main sequence
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rdc("mask reset", 8'h38, 32'h0000_0000);
		rdc("raw reset", 8'h3c, 32'h0000_0000);
		rdc("masked reset", 8'h40, 32'h0000_0000);
		rdc("clear read", 8'h44, 32'h0000_0000);
		rdc("dma reset", 8'h48, 32'h0000_0000);
		for (int k = 0; k < 10; k++) begin
			b = 32'h0000_0001 << pos[k];
			fire(10'h001 << k);
			rdc("raw flag", 8'h3c, b);
			rdc("masked while off", 8'h40, 32'h0000_0000);
			apb(1'b1, 8'h38, b);
			rdc("mask readback", 8'h38, b);
			rdc("masked flag", 8'h40, b);
			@(negedge pclk);
			chk("irq on", 32'h0000_0001, {31'h0, uart_irq});
			apb(1'b1, 8'h44, ~b);
			rdc("raw kept", 8'h3c, b);
			apb(1'b1, 8'h44, b);
			rdc("raw cleared", 8'h3c, 32'h0000_0000);
			@(negedge pclk);
			chk("irq off", 32'h0000_0000, {31'h0, uart_irq});
			apb(1'b1, 8'h38, 32'h0000_0000);
		end
		fire(10'h3ff);
		rdc("raw all", 8'h3c, 32'h0000_1ff2);
		apb(1'b1, 8'h38, 32'hffff_ffff);
		rdc("mask reserved", 8'h38, 32'h0000_1ff2);
		chk("mask port", 32'h0000_1ff2, event_mask);
		rdc("masked all", 8'h40, 32'h0000_1ff2);
		apb(1'b1, 8'h3c, 32'hffff_ffff);
		apb(1'b1, 8'h44, 32'hffff_e00d);
		rdc("raw after reserved", 8'h3c, 32'h0000_1ff2);
		apb(1'b1, 8'h44, 32'hffff_ffff);
		rdc("raw all cleared", 8'h3c, 32'h0000_0000);
		apb(1'b1, 8'h48, 32'hffff_ffff);
		rdc("dma readback", 8'h48, 32'h0000_000b);
		chk("mapped error", 32'h0000_0000, {31'h0, err});
		chk("dma port", 32'h0000_000b, dma_control);
		rdc("unmapped read", 8'h4c, 32'h0000_0000);
		chk("unmapped error", 32'h0000_0001, {31'h0, err});
		// Receive event held high at the clear's access edge: the set wins
		fire(10'h002);
		fork
			apb(1'b1, 8'h44, 32'h0000_0010);
			begin
				repeat (2) @(posedge pclk);
				ev <= 10'h002;
				@(posedge pclk);
				ev <= 10'h000;
			end
		join
		rdc("set beats clear", 8'h3c, 32'h0000_0010);
		apb(1'b1, 8'h44, 32'h0000_0010);
		rdc("raw after set clear", 8'h3c, 32'h0000_0000);
		give_verdict();
	end
endmodule

// ==== verilog/uis_apb_dec.sv ====
// APB address decode for the event status block.
// Assumes a zero-wait-state slave; pready is tied high by the top.
`timescale 1ns/10ps
module uis_apb_dec (
	// Bus request
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [uis_pkg::ADDR_W-1:0] paddr,
	// Decoded strobes
	output logic wr_mask,
	output logic wr_clear,
	output logic wr_dma,
	output logic hit_mask,
	output logic hit_raw,
	output logic hit_masked,
	output logic hit_dma,
	output logic hit_any
);
	logic wr_acc;
	logic hit_clear;
	assign wr_acc = psel & penable & pwrite;
	assign hit_mask = (paddr == uis_pkg::OFS_EVENT_MASK);
	assign hit_raw = (paddr == uis_pkg::OFS_RAW_STATUS);
	assign hit_masked = (paddr == uis_pkg::OFS_MASKED_STATUS);
	assign hit_dma = (paddr == uis_pkg::OFS_DMA_CONTROL);
	assign hit_clear = (paddr == uis_pkg::OFS_EVENT_CLEAR);
	assign hit_any = hit_mask | hit_raw | hit_masked | hit_dma | hit_clear;
	assign wr_mask = wr_acc & hit_mask;
	assign wr_clear = wr_acc & hit_clear;
	assign wr_dma = wr_acc & hit_dma;
endmodule

// ==== verilog/uis_flags.sv ====
// Sticky pending flags, one per event bit position.
// Assumes event inputs are single-cycle or level pulses on pclk.
`timescale 1ns/10ps
module uis_flags #(
	parameter logic [31:0] VALID = uis_pkg::EVENT_BITS
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Events and clears
	input wire logic [31:0] set_in,
	input wire logic [31:0] clr_in,
	// Flags
	output logic [31:0] flags
);
	logic [31:0] flags_ff;
	logic [31:0] nxt_flags;
	// Set wins over a clear in the same cycle
	assign nxt_flags = ((flags_ff & ~clr_in) | set_in) & VALID;
	assign flags = flags_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_ff <= uis_pkg::RESET_ZERO;
		end else begin
			flags_ff <= nxt_flags;
		end
	end
	a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
		(set_in[uis_pkg::BIT_CTS] |=> flags_ff[uis_pkg::BIT_CTS]))
		else $error("cts set lost");
	a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
		((flags_ff & ~VALID) == 32'h0000_0000))
		else $error("reserved flag set");
endmodule

// ==== verilog/uis_pkg.sv ====
// Constants for the serial port event status and clear block.
// Assumes an APB slave at the serial port base; offsets are byte addresses.
//
// Overview of operation
// - Raw status at 0x3C, reset zero, cts bit1
// - Raw bit 6 shows receive timeout pending
// - Raw bit 7 shows framing error pending
// - Raw bit 8 shows parity error pending
// - Raw bit 9 shows break pending
// - Raw bit 10 shows overrun pending
// - Raw bit 12 shows tx empty pending
// - Raw bits 4,5,11: receive, transmit, flow stop
// - Masked status at 0x40, reset zero, same bits
// - Masked bits 4,5: receive, transmit
// - Masked bits 6..10: timeout and errors
// - Masked bits 11,12; 31:13 reserved
// - Clear register at 0x44, write-only event bits
// - Write one clears event, zero no effect
// - Clear bits 1,4,5: cts, receive, transmit
// - Clear bit 6 clears receive timeout
// - Clear bits 7..10 clear error events
// - Clear bits 11,12: flow stop, tx empty
// - DMA control register at 0x48
// - Mask register at 0x38, one enables event
// - Mask register reads back programmed event bits; reserved bits read zero
package uis_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] OFS_EVENT_MASK = 8'h38;
	localparam logic [7:0] OFS_RAW_STATUS = 8'h3c;
	localparam logic [7:0] OFS_MASKED_STATUS = 8'h40;
	localparam logic [7:0] OFS_EVENT_CLEAR = 8'h44;
	localparam logic [7:0] OFS_DMA_CONTROL = 8'h48;
	// Event bit positions
	localparam int unsigned BIT_CTS = 1;
	localparam int unsigned BIT_RECEIVE = 4;
	localparam int unsigned BIT_TRANSMIT = 5;
	localparam int unsigned BIT_RX_TIMEOUT = 6;
	localparam int unsigned BIT_FRAMING = 7;
	localparam int unsigned BIT_PARITY = 8;
	localparam int unsigned BIT_BREAK = 9;
	localparam int unsigned BIT_OVERRUN = 10;
	localparam int unsigned BIT_FLOW_STOP = 11;
	localparam int unsigned BIT_TX_EMPTY = 12;
	localparam logic [31:0] EVENT_BITS = 32'h0000_1ff2;
	localparam logic [31:0] DMA_BITS = 32'h0000_000b;
	localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
endpackage

// ==== verilog/uis_top.sv ====
// Event status, mask and clear registers of the serial port.
// Assumes an APB master on pclk and event pulses from the port logic.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
module uis_top (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [uis_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Event sources, one-cycle or level
	input wire logic cts_event,
	input wire logic receive_event,
	input wire logic transmit_event,
	input wire logic rx_timeout_event,
	input wire logic framing_event,
	input wire logic parity_event,
	input wire logic break_event,
	input wire logic overrun_event,
	input wire logic flow_stop_event,
	input wire logic tx_empty_event,
	// To the rest of the port
	output logic [31:0] dma_control,
	output logic [31:0] event_mask,
	output logic uart_irq
);
	//==========================================
	// Decode
	logic wr_mask, wr_clear, wr_dma;
	logic hit_mask, hit_raw, hit_masked, hit_dma, hit_any;
	logic [31:0] set_vec;
	logic [31:0] clr_vec;
	logic [31:0] raw_event_status;
	logic [31:0] masked_event_status;
	logic [31:0] event_mask_ff;
	logic [31:0] dma_control_ff;
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;
	logic rd_acc;
	// Per-event views of the raw, masked and clear registers
	logic cts_raw_flag;
	logic receive_raw_flag;
	logic transmit_raw_flag;
	logic rx_timeout_raw_flag;
	logic framing_raw_flag;
	logic parity_raw_flag;
	logic break_raw_flag;
	logic overrun_raw_flag;
	logic flow_stop_raw_flag;
	logic tx_empty_raw_flag;
	logic cts_masked_flag;
	logic receive_masked_flag;
	logic transmit_masked_flag;
	logic rx_timeout_masked_flag;
	logic framing_masked_flag;
	logic parity_masked_flag;
	logic break_masked_flag;
	logic overrun_masked_flag;
	logic flow_stop_masked_flag;
	logic tx_empty_masked_flag;
	logic cts_clear_bit;
	logic receive_clear_bit;
	logic transmit_clear_bit;
	logic rx_timeout_clear_bit;
	logic framing_clear_bit;
	logic parity_clear_bit;
	logic break_clear_bit;
	logic overrun_clear_bit;
	logic flow_stop_clear_bit;
	logic tx_empty_clear_bit;

	uis_apb_dec u_dec (
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.wr_mask(wr_mask),
		.wr_clear(wr_clear),
		.wr_dma(wr_dma),
		.hit_mask(hit_mask),
		.hit_raw(hit_raw),
		.hit_masked(hit_masked),
		.hit_dma(hit_dma),
		.hit_any(hit_any)
	);

	//==========================================
	// Pending flags
	always_comb begin
		set_vec = uis_pkg::RESET_ZERO;
		set_vec[uis_pkg::BIT_CTS] = cts_event;
		set_vec[uis_pkg::BIT_RECEIVE] = receive_event;
		set_vec[uis_pkg::BIT_TRANSMIT] = transmit_event;
		set_vec[uis_pkg::BIT_RX_TIMEOUT] = rx_timeout_event;
		set_vec[uis_pkg::BIT_FRAMING] = framing_event;
		set_vec[uis_pkg::BIT_PARITY] = parity_event;
		set_vec[uis_pkg::BIT_BREAK] = break_event;
		set_vec[uis_pkg::BIT_OVERRUN] = overrun_event;
		set_vec[uis_pkg::BIT_FLOW_STOP] = flow_stop_event;
		set_vec[uis_pkg::BIT_TX_EMPTY] = tx_empty_event;
	end
	// Only event positions clear; reserved bits of the write are dropped
	assign clr_vec = wr_clear ? (pwdata & uis_pkg::EVENT_BITS) : uis_pkg::RESET_ZERO;

	uis_flags #(
		.VALID(uis_pkg::EVENT_BITS)
	) u_flags (
		.pclk(pclk),
		.presetn(presetn),
		.set_in(set_vec),
		.clr_in(clr_vec),
		.flags(raw_event_status)
	);

	//==========================================
	// Per-event flags
	// One gate per event, so a mask fault shows on its own bit only
	function automatic logic masked_bit(input logic [31:0] raw, input logic [31:0] mask, input int unsigned pos);
		masked_bit = raw[pos] & mask[pos];
	endfunction

	assign cts_raw_flag = raw_event_status[uis_pkg::BIT_CTS];
	assign receive_raw_flag = raw_event_status[uis_pkg::BIT_RECEIVE];
	assign transmit_raw_flag = raw_event_status[uis_pkg::BIT_TRANSMIT];
	assign rx_timeout_raw_flag = raw_event_status[uis_pkg::BIT_RX_TIMEOUT];
	assign framing_raw_flag = raw_event_status[uis_pkg::BIT_FRAMING];
	assign parity_raw_flag = raw_event_status[uis_pkg::BIT_PARITY];
	assign break_raw_flag = raw_event_status[uis_pkg::BIT_BREAK];
	assign overrun_raw_flag = raw_event_status[uis_pkg::BIT_OVERRUN];
	assign flow_stop_raw_flag = raw_event_status[uis_pkg::BIT_FLOW_STOP];
	assign tx_empty_raw_flag = raw_event_status[uis_pkg::BIT_TX_EMPTY];

	assign cts_masked_flag = masked_bit(raw_event_status, event_mask_ff, uis_pkg::BIT_CTS);
	assign receive_masked_flag = masked_bit(raw_event_status, event_mask_ff, uis_pkg::BIT_RECEIVE);
	assign transmit_masked_flag = masked_bit(raw_event_status, event_mask_ff, uis_pkg::BIT_TRANSMIT);
	assign rx_timeout_masked_flag = masked_bit(raw_event_status, event_mask_ff, uis_pkg::BIT_RX_TIMEOUT);
	assign framing_masked_flag = masked_bit(raw_event_status, event_mask_ff, uis_pkg::BIT_FRAMING);
	assign parity_masked_flag = masked_bit(raw_event_status, event_mask_ff, uis_pkg::BIT_PARITY);
	assign break_masked_flag = masked_bit(raw_event_status, event_mask_ff, uis_pkg::BIT_BREAK);
	assign overrun_masked_flag = masked_bit(raw_event_status, event_mask_ff, uis_pkg::BIT_OVERRUN);
	assign flow_stop_masked_flag = masked_bit(raw_event_status, event_mask_ff, uis_pkg::BIT_FLOW_STOP);
	assign tx_empty_masked_flag = masked_bit(raw_event_status, event_mask_ff, uis_pkg::BIT_TX_EMPTY);

	assign cts_clear_bit = clr_vec[uis_pkg::BIT_CTS];
	assign receive_clear_bit = clr_vec[uis_pkg::BIT_RECEIVE];
	assign transmit_clear_bit = clr_vec[uis_pkg::BIT_TRANSMIT];
	assign rx_timeout_clear_bit = clr_vec[uis_pkg::BIT_RX_TIMEOUT];
	assign framing_clear_bit = clr_vec[uis_pkg::BIT_FRAMING];
	assign parity_clear_bit = clr_vec[uis_pkg::BIT_PARITY];
	assign break_clear_bit = clr_vec[uis_pkg::BIT_BREAK];
	assign overrun_clear_bit = clr_vec[uis_pkg::BIT_OVERRUN];
	assign flow_stop_clear_bit = clr_vec[uis_pkg::BIT_FLOW_STOP];
	assign tx_empty_clear_bit = clr_vec[uis_pkg::BIT_TX_EMPTY];

	// Reserved positions stay zero in the masked view
	always_comb begin
		masked_event_status = uis_pkg::RESET_ZERO;
		masked_event_status[uis_pkg::BIT_CTS] = cts_masked_flag;
		masked_event_status[uis_pkg::BIT_RECEIVE] = receive_masked_flag;
		masked_event_status[uis_pkg::BIT_TRANSMIT] = transmit_masked_flag;
		masked_event_status[uis_pkg::BIT_RX_TIMEOUT] = rx_timeout_masked_flag;
		masked_event_status[uis_pkg::BIT_FRAMING] = framing_masked_flag;
		masked_event_status[uis_pkg::BIT_PARITY] = parity_masked_flag;
		masked_event_status[uis_pkg::BIT_BREAK] = break_masked_flag;
		masked_event_status[uis_pkg::BIT_OVERRUN] = overrun_masked_flag;
		masked_event_status[uis_pkg::BIT_FLOW_STOP] = flow_stop_masked_flag;
		masked_event_status[uis_pkg::BIT_TX_EMPTY] = tx_empty_masked_flag;
	end
	assign uart_irq = cts_masked_flag | receive_masked_flag | transmit_masked_flag |
		rx_timeout_masked_flag | framing_masked_flag | parity_masked_flag |
		break_masked_flag | overrun_masked_flag | flow_stop_masked_flag |
		tx_empty_masked_flag;
	assign event_mask = event_mask_ff;
	assign dma_control = dma_control_ff;

	//==========================================
	// Registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_mask_ff <= uis_pkg::RESET_ZERO;
		end else if (wr_mask) begin
			event_mask_ff <= pwdata & uis_pkg::EVENT_BITS;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dma_control_ff <= uis_pkg::RESET_ZERO;
		end else if (wr_dma) begin
			dma_control_ff <= pwdata & uis_pkg::DMA_BITS;
		end
	end

	//==========================================
	// Read path, captured in setup so data is a flop at access
	assign rd_acc = psel & ~penable & ~pwrite;
	assign nxt_prdata = hit_mask ? event_mask_ff :
		hit_raw ? raw_event_status :
		hit_masked ? masked_event_status :
		hit_dma ? dma_control_ff : uis_pkg::RESET_ZERO;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= uis_pkg::RESET_ZERO;
		end else if (rd_acc) begin
			prdata_ff <= nxt_prdata;
		end
	end
	assign prdata = prdata_ff;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit_any;

	//==========================================
	// Checks
	// Register and masked view behaviour
	a_masked_and: assert property (@(posedge pclk) disable iff (!presetn)
		(masked_event_status == (raw_event_status & event_mask_ff)) && (uart_irq == (|masked_event_status)))
		else $error("masked view wrong");
	a_clear_works: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_clear && pwdata[uis_pkg::BIT_OVERRUN] && !overrun_event) |=> !raw_event_status[uis_pkg::BIT_OVERRUN])
		else $error("overrun not cleared");
	a_zero_keeps: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_clear && !pwdata[uis_pkg::BIT_RX_TIMEOUT] && raw_event_status[uis_pkg::BIT_RX_TIMEOUT])
		|=> raw_event_status[uis_pkg::BIT_RX_TIMEOUT])
		else $error("zero write cleared timeout");
	a_event_sets: assert property (@(posedge pclk) disable iff (!presetn)
		framing_event |=> raw_event_status[uis_pkg::BIT_FRAMING])
		else $error("framing not captured");
	a_mask_read: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_acc && hit_mask) |=> (prdata == $past(event_mask_ff)))
		else $error("mask readback wrong");
	a_raw_read: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_acc && hit_raw) |=> (prdata == $past(raw_event_status)))
		else $error("raw readback wrong");
	a_resv_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && !pwrite && !hit_dma) |-> ((prdata & ~uis_pkg::EVENT_BITS) == uis_pkg::RESET_ZERO))
		else $error("reserved bits nonzero");
	a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr_mask |=> (event_mask_ff == ($past(pwdata) & uis_pkg::EVENT_BITS)))
		else $error("mask write lost");

	// Write side, bus protocol and quiet interrupt
	a_dma_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr_dma |=> (dma_control_ff == ($past(pwdata) & uis_pkg::DMA_BITS)))
		else $error("dma write lost");
	a_read_holds: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && !pwrite) |=> $stable(prdata))
		else $error("read data moved");
	a_irq_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		(event_mask_ff == uis_pkg::RESET_ZERO) |-> !uart_irq)
		else $error("irq with all masked");
	a_error_keeps: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && pslverr) |=> $stable(event_mask_ff) && $stable(dma_control_ff))
		else $error("unmapped write landed");

	//==========================================
	// Per-event clear and capture
	// A clear only counts with its event quiet, as set wins
	a_cts_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(cts_clear_bit && !cts_event)
		|=> !cts_raw_flag)
		else $error("cts clear lost");
	a_receive_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(receive_clear_bit && !receive_event)
		|=> !receive_raw_flag)
		else $error("receive clear lost");
	a_transmit_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(transmit_clear_bit && !transmit_event)
		|=> !transmit_raw_flag)
		else $error("transmit clear lost");
	a_rx_timeout_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(rx_timeout_clear_bit && !rx_timeout_event)
		|=> !rx_timeout_raw_flag)
		else $error("timeout clear lost");
	a_framing_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(framing_clear_bit && !framing_event)
		|=> !framing_raw_flag)
		else $error("framing clear lost");
	a_parity_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(parity_clear_bit && !parity_event)
		|=> !parity_raw_flag)
		else $error("parity clear lost");
	a_break_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(break_clear_bit && !break_event)
		|=> !break_raw_flag)
		else $error("break clear lost");
	a_overrun_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(overrun_clear_bit && !overrun_event)
		|=> !overrun_raw_flag)
		else $error("overrun clear lost");
	a_flow_stop_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(flow_stop_clear_bit && !flow_stop_event)
		|=> !flow_stop_raw_flag)
		else $error("flow stop clear lost");
	a_tx_empty_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(tx_empty_clear_bit && !tx_empty_event)
		|=> !tx_empty_raw_flag)
		else $error("tx empty clear lost");

	// Every event but framing (checked in a_event_sets) is captured at the edge after it
	a_cts_sets: assert property (@(posedge pclk) disable iff (!presetn)
		cts_event |=> cts_raw_flag)
		else $error("cts not captured");
	a_receive_sets: assert property (@(posedge pclk) disable iff (!presetn)
		receive_event |=> receive_raw_flag)
		else $error("receive not captured");
	a_transmit_sets: assert property (@(posedge pclk) disable iff (!presetn)
		transmit_event |=> transmit_raw_flag)
		else $error("transmit not captured");
	a_rx_timeout_sets: assert property (@(posedge pclk) disable iff (!presetn)
		rx_timeout_event |=> rx_timeout_raw_flag)
		else $error("timeout not captured");
	a_parity_sets: assert property (@(posedge pclk) disable iff (!presetn)
		parity_event |=> parity_raw_flag)
		else $error("parity not captured");
	a_break_sets: assert property (@(posedge pclk) disable iff (!presetn)
		break_event |=> break_raw_flag)
		else $error("break not captured");
	a_overrun_sets: assert property (@(posedge pclk) disable iff (!presetn)
		overrun_event |=> overrun_raw_flag)
		else $error("overrun not captured");
	a_flow_stop_sets: assert property (@(posedge pclk) disable iff (!presetn)
		flow_stop_event |=> flow_stop_raw_flag)
		else $error("flow stop not captured");
	a_tx_empty_sets: assert property (@(posedge pclk) disable iff (!presetn)
		tx_empty_event |=> tx_empty_raw_flag)
		else $error("tx empty not captured");

	//==========================================
	// Scenarios worth seeing
	c_irq_rise: cover property (@(posedge pclk) disable iff (!presetn) $rose(uart_irq));
	c_clear_tx: cover property (@(posedge pclk) disable iff (!presetn)
		wr_clear && raw_event_status[uis_pkg::BIT_TX_EMPTY]);
	c_set_clear: cover property (@(posedge pclk) disable iff (!presetn)
		wr_clear && pwdata[uis_pkg::BIT_RECEIVE] && receive_event);
	c_irq_fall: cover property (@(posedge pclk) disable iff (!presetn)
		$fell(uart_irq));
	c_unmapped: cover property (@(posedge pclk) disable iff (!presetn)
		psel && penable && pslverr);
endmodule
